// ---- vfd_pkg.sv ----
`default_nettype none
package vfd_pkg;
  localparam int INSTR_W     = 32;
  localparam int SLOTS       = 8;
  localparam int SLOT_W      = 3;
  localparam int UNITS       = 8;
  localparam int SIDES       = 2;
  localparam int CHAIN_BIT   = 0;
  localparam int KIND_LSB    = 1;
  localparam int KIND_W      = 2;
  localparam int SIDE_BIT    = 3;
  localparam int SIZE_LSB    = 4;
  localparam int SIZE_W      = 2;
  localparam int FETCH_BYTES = 32;

  localparam logic [KIND_W-1:0] KIND_LOGIC = 2'h0;
  localparam logic [KIND_W-1:0] KIND_SHIFT = 2'h1;
  localparam logic [KIND_W-1:0] KIND_MULT  = 2'h2;
  localparam logic [KIND_W-1:0] KIND_ADDR  = 2'h3;

  localparam logic [SIZE_W-1:0] SIZE_BYTE = 2'h0;
  localparam logic [SIZE_W-1:0] SIZE_HALF = 2'h1;
  localparam logic [SIZE_W-1:0] SIZE_WORD = 2'h2;
  localparam logic [SIZE_W-1:0] SIZE_RSVD = 2'h3;

  typedef logic [INSTR_W-1:0]           vfd_instr_t;
  typedef vfd_instr_t [SLOTS-1:0]       vfd_pkt_t;
  typedef vfd_instr_t [UNITS-1:0]       vfd_units_t;
  typedef logic [SLOT_W-1:0]            vfd_slot_t;
  typedef logic [SLOTS-1:0]             vfd_mask_t;
  typedef logic [SIDES-1:0][SIZE_W-1:0] vfd_size_t;

  typedef enum {
    VFD_FETCH,
    VFD_DISPATCH
  } vfd_state_e;
endpackage
`default_nettype wire

// ---- vfd_ep_if.sv ----
`timescale 1ns/1ps
`default_nettype none
interface vfd_ep_if;
  import vfd_pkg::*;
  vfd_pkt_t  pkt;
  vfd_slot_t start;
  vfd_mask_t mask;
  vfd_slot_t next_start;
  logic      last;

  modport finder (
    input  pkt,
    input  start,
    output mask,
    output next_start,
    output last
  );
  modport user (
    output pkt,
    output start,
    input  mask,
    input  next_start,
    input  last
  );
endinterface
`default_nettype wire

// ---- vfd_ep_finder.sv ----
`timescale 1ns/1ps
`default_nettype none
// marks the slots of one execute packet, from start up to the first
// slot whose chain bit is clear, or to the top slot of the packet
module vfd_ep_finder (
  vfd_ep_if.finder ep
);
  import vfd_pkg::*;

  always_comb begin
    logic      stop;
    vfd_slot_t end_slot;
    stop     = 1'b0;
    end_slot = SLOT_W'(SLOTS - 1);
    ep.mask  = '0;
    for (int i = 0; i < SLOTS; i++) begin
      if (!stop && (i >= int'(ep.start))) begin
        ep.mask[i] = 1'b1;
        if (!ep.pkt[i][CHAIN_BIT]) begin
          stop     = 1'b1;
          end_slot = SLOT_W'(i);
        end
      end
    end
    ep.next_start = end_slot + SLOT_W'(1);
    ep.last       = (end_slot == SLOT_W'(SLOTS - 1));
  end
endmodule
`default_nettype wire

// ---- vfd_fetch_dispatch.sv ----
// Notes on behaviour
// - packets of 256 bits hold eight 32-bit slots taken lowest first.
// - a set bit 0 chains the next slot into the same execute packet.
// - a clear bit 0 ends the execute packet; the next slot opens one.
// - an execute packet holds one to eight instructions issued together.
// - one to eight execute packets per fetch packet, found by chain bits.
// - exactly one execute packet is dispatched per clock in the dispatch state; none while fetching.
// - no new fetch is requested until the last execute packet is out.
// - all addressed units are driven in one cycle; the rest stay idle.
// - load and store decode byte, half-word and word access sizes.
// - units form two sides of logic, shift, multiply and address units.
`timescale 1ns/1ps
`default_nettype none
module vfd_fetch_dispatch #(
  parameter int                ADDR_W     = 32,
  parameter logic [ADDR_W-1:0] RESET_ADDR = '0
) (
  input  wire logic                core_clk_i,
  input  wire logic                rst_n_i,
  output var  logic                fetch_req_o,
  output var  logic [ADDR_W-1:0]   fetch_addr_o,
  input  wire logic                fetch_valid_i,
  input  wire vfd_pkg::vfd_pkt_t   fetch_data_i,
  output var  logic [vfd_pkg::UNITS-1:0] unit_valid_o,
  output var  vfd_pkg::vfd_units_t unit_instr_o,
  output var  vfd_pkg::vfd_size_t  access_size_o
);
  import vfd_pkg::*;

  vfd_state_e        state;
  vfd_state_e        next_state;
  vfd_pkt_t          pkt;
  vfd_pkt_t          next_pkt;
  vfd_slot_t         start;
  vfd_slot_t         next_start;
  logic              next_fetch_req;
  logic [ADDR_W-1:0] next_fetch_addr;
  logic [UNITS-1:0]  next_unit_valid;
  vfd_units_t        next_unit_instr;
  vfd_size_t         next_access_size;

  vfd_ep_if ep ();

  assign ep.pkt   = pkt;
  assign ep.start = start;

  vfd_ep_finder u_finder (
    .ep (ep.finder)
  );

  ////////////////////////////////////////////////////////////////////////
  // fetch sequencing

  always_comb begin
    next_state      = state;
    next_pkt        = pkt;
    next_start      = start;
    next_fetch_req  = fetch_req_o;
    next_fetch_addr = fetch_addr_o;
    case (state)
      VFD_FETCH: begin
        if (fetch_valid_i) begin
          next_pkt       = fetch_data_i;
          next_start     = '0;
          next_fetch_req = 1'b0;
          next_state     = VFD_DISPATCH;
        end
      end
      VFD_DISPATCH: begin
        next_start = ep.next_start;
        if (ep.last) begin
          next_fetch_req  = 1'b1;
          next_fetch_addr = fetch_addr_o + ADDR_W'(FETCH_BYTES);
          next_state      = VFD_FETCH;
        end
      end
      default: begin
        next_state = VFD_FETCH;
      end
    endcase
  end

  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state        <= VFD_FETCH;
      pkt          <= '0;
      start        <= '0;
      fetch_req_o  <= 1'b1;
      fetch_addr_o <= RESET_ADDR;
    end else begin
      state        <= next_state;
      pkt          <= next_pkt;
      start        <= next_start;
      fetch_req_o  <= next_fetch_req;
      fetch_addr_o <= next_fetch_addr;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // routing of the current execute packet to the units

  always_comb begin
    int          unit;
    logic        side;
    logic [KIND_W-1:0] kind;
    logic [SIZE_W-1:0] size;
    unit             = 0;
    side             = 1'b0;
    kind             = KIND_LOGIC;
    size             = SIZE_WORD;
    next_unit_valid  = '0;
    next_unit_instr  = '0;
    next_access_size = '0;
    for (int i = 0; i < SLOTS; i++) begin
      if ((state == VFD_DISPATCH) && ep.mask[i]) begin
        side = pkt[i][SIDE_BIT];
        kind = pkt[i][KIND_LSB +: KIND_W];
        unit = int'({side, kind});
        next_unit_valid[unit] = 1'b1;
        next_unit_instr[unit] = pkt[i];
        if (kind == KIND_ADDR) begin
          size = pkt[i][SIZE_LSB +: SIZE_W];
          // reserved size code falls back to a whole word
          next_access_size[side] = (size == SIZE_RSVD) ? SIZE_WORD
                                                       : size;
        end
      end
    end
  end

  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      unit_valid_o  <= '0;
      unit_instr_o  <= '0;
      access_size_o <= '0;
    end else begin
      unit_valid_o  <= next_unit_valid;
      unit_instr_o  <= next_unit_instr;
      access_size_o <= next_access_size;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // checks

  logic             chain_ok;
  logic             break_ok;
  logic             last_ep;
  logic             side_b_any;
  logic [UNITS-1:0] ep_units;

  assign last_ep = (state == VFD_DISPATCH) && ep.last;

  always_comb begin
    chain_ok   = 1'b1;
    break_ok   = 1'b1;
    side_b_any = 1'b0;
    ep_units   = '0;
    // units named by the current execute packet, repeats folded into one
    for (int i = 0; i < SLOTS; i++) begin
      if (ep.mask[i]) begin
        ep_units[{pkt[i][SIDE_BIT], pkt[i][KIND_LSB +: KIND_W]}] = 1'b1;
        side_b_any = side_b_any | pkt[i][SIDE_BIT];
      end
    end
    for (int i = 0; i < SLOTS - 1; i++) begin
      if (ep.mask[i] && pkt[i][CHAIN_BIT] && !ep.mask[i+1]) begin
        chain_ok = 1'b0;
      end
      if (ep.mask[i] && !pkt[i][CHAIN_BIT] && ep.mask[i+1]) begin
        break_ok = 1'b0;
      end
    end
  end

  default clocking cb @(posedge core_clk_i);
  endclocking
  default disable iff (!rst_n_i);

  sequence s_dispatching;
    state == VFD_DISPATCH;
  endsequence

  sequence s_last_ep;
    (state == VFD_DISPATCH) && ep.last;
  endsequence

  sequence s_long_run;
    (state == VFD_DISPATCH) [*8];
  endsequence

  chk_chain_joins: assert property (
    s_dispatching |-> chain_ok)
    else $error("chained slot left out of execute packet");

  chk_chain_breaks: assert property (
    s_dispatching |-> break_ok)
    else $error("execute packet runs past a cleared chain bit");

  chk_ep_size: assert property (
    s_dispatching |-> (ep.mask != '0) && (ep.mask[start]))
    else $error("execute packet empty or not at start slot");

  chk_slot_order: assert property (
    (s_dispatching and !ep.last) |=>
      (start == $past(ep.next_start)) && (start > $past(start)))
    else $error("slots not taken lowest first");

  chk_ep_count: assert property (
    s_long_run |=> state == VFD_FETCH)
    else $error("more than eight execute packets in a fetch packet");

  chk_one_per_clk: assert property (
    s_dispatching |=> (unit_valid_o != '0) &&
      (unit_valid_o == $past(ep_units)))
    else $error("execute packet not issued in one cycle");

  chk_fetch_after: assert property (
    $rose(fetch_req_o) |-> $past(last_ep))
    else $error("fetch requested before packet was used up");

  chk_refetch: assert property (
    s_last_ep |=> fetch_req_o && (state == VFD_FETCH) &&
      (fetch_addr_o == $past(fetch_addr_o) + ADDR_W'(FETCH_BYTES)))
    else $error("no fetch after last execute packet");

  chk_idle_units: assert property (
    (state == VFD_FETCH) |=> unit_valid_o == '0)
    else $error("unit driven while no packet dispatched");

  chk_hold_wait: assert property (
    (state == VFD_FETCH && !fetch_valid_i) |=>
      (state == VFD_FETCH) && (unit_valid_o == '0))
    else $error("dispatch without fetch data");

  chk_size_legal: assert property (
    unit_valid_o[int'({1'b0, KIND_ADDR})] |->
      access_size_o[0] != SIZE_RSVD)
    else $error("illegal access size on address unit");

  chk_side_route: assert property (
    s_dispatching |=> ((unit_valid_o[UNITS-1:UNITS/2] != '0) ==
      $past(side_b_any)))
    else $error("instruction routed to wrong side");
endmodule
`default_nettype wire

// ---- vfd_prog_mem.sv ----
`timescale 1ns/1ps
`default_nettype none
module vfd_prog_mem (
  input  wire logic              core_clk_i,
  input  wire logic              rst_n_i,
  input  wire logic              fetch_req_i,
  input  wire logic [31:0]       fetch_addr_i,
  output var  logic              fetch_valid_o,
  output var  vfd_pkg::vfd_pkt_t fetch_data_o
);
  import vfd_pkg::*;
  vfd_pkt_t   pkt_mem [4];
  int         wait_mem [4];
  int         cnt;
  vfd_pkt_t   last;
  logic [1:0] idx;
  assign idx = fetch_addr_i[6:5];
  // valid comes once the programmed wait has run out; each cycle of valid counts as taken and restarts the wait
  assign fetch_valid_o = fetch_req_i && (cnt >= wait_mem[idx]);
  // between transfers the data lines show the inverse of the last packet
  assign fetch_data_o = fetch_valid_o ? pkt_mem[idx] : ~last;
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cnt <= 0;
      last <= '0;
    end else if (fetch_valid_o) begin
      cnt <= 0;
      last <= pkt_mem[idx];
    end else if (fetch_req_i) begin
      cnt <= cnt + 1;
    end
  end
endmodule
`default_nettype wire

// ---- testbench.sv ----
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import vfd_pkg::*;
  typedef struct {vfd_pkt_t pkt; int dly;} vfd_row_s;
  logic        core_clk_i;
  logic        rst_n_i;
  logic        fetch_req;
  logic        fetch_valid;
  logic [31:0] fetch_addr;
  vfd_pkt_t    fetch_data;
  logic [7:0]  unit_valid;
  vfd_units_t  unit_instr;
  vfd_size_t   access_size;
  vfd_row_s    rows [3];
  int          fails;
  int          n_checks;

  vfd_fetch_dispatch i_dut (
    .core_clk_i(core_clk_i), .rst_n_i(rst_n_i), .fetch_req_o(fetch_req),
    .fetch_addr_o(fetch_addr), .fetch_valid_i(fetch_valid),
    .fetch_data_i(fetch_data), .unit_valid_o(unit_valid),
    .unit_instr_o(unit_instr), .access_size_o(access_size));
  vfd_prog_mem i_mem (
    .core_clk_i(core_clk_i), .rst_n_i(rst_n_i), .fetch_req_i(fetch_req),
    .fetch_addr_i(fetch_addr), .fetch_valid_o(fetch_valid),
    .fetch_data_o(fetch_data));

  always #10 core_clk_i = ~core_clk_i;
  ////////////////////////////////////////////////////////////////////////
  task automatic chk(input string nm, input logic [255:0] exp,
                     input logic [255:0] seen);
    n_checks++;
    if (seen !== exp) begin
      fails++;
      $display("BAD %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic close_out;
    $display("checks %0d mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  function automatic vfd_instr_t mk(input int u, input int sz,
                                    input bit ch, input int tg);
    return {tg[7:0], 18'h0, sz[1:0], u[2], u[1:0], ch};
  endfunction
  // expected unit outputs of the execute packet opening at slot s
  function automatic int ref_ep(input vfd_pkt_t p, input int s,
    output logic [7:0] v, output vfd_units_t ins, output vfd_size_t sz);
    int u;
    v = '0;
    ins = '0;
    sz = '0;
    for (int i = s; i < 8; i++) begin
      u = int'(p[i][2:1]) + 4 * int'(p[i][3]);
      v[u] = 1'b1;
      ins[u] = p[i];
      if (p[i][2:1] == KIND_ADDR)
        sz[p[i][3]] = (p[i][5:4] == SIZE_RSVD) ? SIZE_WORD : p[i][5:4];
      if (!p[i][0]) return i + 1;
    end
    return 8;
  endfunction
  task automatic run_row(input int r);
    logic       taken;
    int         s;
    int         nxt;
    logic [7:0] v;
    vfd_units_t ins;
    vfd_size_t  sz;
    taken = 0;
    s = 0;
    while (!taken) begin
      @(negedge core_clk_i);
      taken = (fetch_req === 1'b1) && (fetch_valid === 1'b1);
      if (fetch_req === 1'b1) begin
        chk("addr", 256'(32 * r), 256'(fetch_addr));
      end
      @(posedge core_clk_i);
      #1;
      chk("idle", '0, 256'(unit_valid));
    end
    while (s < 8) begin
      @(posedge core_clk_i);
      #1;
      nxt = ref_ep(rows[r].pkt, s, v, ins, sz);
      chk("unit_valid", 256'(v), 256'(unit_valid));
      chk("unit_instr", ins, unit_instr);
      chk("access_size", 256'(sz), 256'(access_size));
      chk("fetch_req", 256'(nxt == 8), 256'(fetch_req));
      s = nxt;
    end
    $display("row %0d done", r);
  endtask
  ////////////////////////////////////////////////////////////////////////
  initial begin
    int u2 [8] = '{0, 1, 4, 5, 6, 7, 5, 3};
    bit c2 [8] = '{1, 0, 0, 1, 1, 1, 1, 0};
    core_clk_i = 0;
    rst_n_i = 0;
    fails = 0;
    n_checks = 0;
    // every row closes its last execute packet at slot 7
    for (int i = 0; i < 8; i++) begin
      rows[0].pkt[i] = mk(i, i / 2, 1, i);
      rows[1].pkt[i] = mk(7 - i, i / 2, 0, 16 + i);
      rows[2].pkt[i] = mk(u2[i], i % 4, c2[i], 32 + i);
    end
    rows[0].dly = 0;
    rows[1].dly = 2;
    rows[2].dly = 5;
    for (int r = 0; r < 3; r++) begin
      i_mem.pkt_mem[r] = rows[r].pkt;
      i_mem.wait_mem[r] = rows[r].dly;
    end
    i_mem.pkt_mem[3] = '0;
    i_mem.wait_mem[3] = 15;
    repeat (3) @(posedge core_clk_i);
    #1;
    rst_n_i = 1;
    for (int r = 0; r < 3; r++) run_row(r);
    // reset while a fetch is still outstanding
    @(posedge core_clk_i);
    #1;
    rst_n_i = 0;
    #1;
    chk("rst req", 256'(1), 256'(fetch_req));
    chk("rst addr", '0, 256'(fetch_addr));
    chk("rst units", '0, 256'(unit_valid));
    chk("rst instr", '0, unit_instr);
    chk("rst size", '0, 256'(access_size));
    repeat (3) @(posedge core_clk_i);
    #1;
    rst_n_i = 1;
    run_row(0);
    $display("reset test done");
    close_out();
  end
  initial begin
    #(20 * 1000);
    fails++;
    $display("watchdog expired");
    close_out();
  end
endmodule
`default_nettype wire
